// ==== hw/bpa_top.sv ====
// Purpose: Backplane analyzer capture control and framer 0-3 vector mask registers.
// Assumes: Host strobes and backplane timing inputs are synchronous to clock.
// Notes:   Capture buffer memory lives outside; this block drives its write port.
//
// Behaviour
// - Channel-select field, bits 15-11, picks channel stored in per-channel mode.
// - Stream-select bits 7-6: data in, data out, signaling in, signaling out.
// - Buffer is written only while capture-enable bit 5 is set.
// - Framer-select bits 4-2 choose which of framers 0-7 is captured.
// - Whole-frame bit 1 at zero: selected channel written once per frame.
// - Whole-frame bit set: every channel up to 32 of each frame written; slow-rate frames end at channel 31.
// - Repeat bit 0 set refills continuously; clear stops after the last fill write, which slow-rate whole-frame never reaches.
// - A pulse marks each last fill write: per-channel word FILL_LEN-1, or the whole-frame channel 32 write.
// - Mask bit one holds its vector status bit at zero.
// - All mask bits reset to zero.
// - Channel timing comes from system clock tick and frame pulse, rate selectable.
`timescale 1ns/1ps
`default_nettype none
module bpa_top #(
  parameter int FILL_LEN    = bpa_pkg::BPA_BUF_WORDS,
  parameter int CK_PER_CHAN = bpa_pkg::BPA_CK_PER_CHAN
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  srst,
  // Host register port
  input  wire bpa_pkg::bpa_host_req_t host_req,
  output logic [15:0]                host_rdata,
  // Backplane timing
  input  wire logic                  frame_pulse,
  input  wire logic                  sys_ck_tick,
  input  wire logic                  rate_fast,
  // Framer stream bytes of the current slot
  input  wire bpa_pkg::bpa_chan_t [7:0] framer_chan,
  // Capture buffer write port
  output bpa_pkg::bpa_buf_wr_t       buf_wr,
  output logic                       cap_full_pulse,
  // Interrupt vector status
  input  wire logic [15:0]           vec_status_raw,
  output logic [15:0]                vec_status_out
);
  import bpa_pkg::*;

  if (FILL_LEN < 1 || FILL_LEN > (1 << BPA_BUF_AW)) begin : g_chk
    $error("FILL_LEN out of range");
  end

  typedef struct packed {
    logic [15:0]           ctrl;
    logic [15:0]           mask;
    bpa_cap_st_t           fsm;
    logic [BPA_BUF_AW-1:0] fill;
    logic [15:0]           rdata;
    bpa_buf_wr_t           bw;
    logic                  full;
  } bpa_top_st_t;

  bpa_top_st_t q;
  bpa_top_st_t d;
  bpa_slot_t   slot;

  // ---------------------------------------------------------------
  // Control field views
  // ---------------------------------------------------------------
  logic        cap_en;
  logic        whole_frame_capture;
  logic        repeat_mode;
  logic [4:0]  capture_channel_select;
  bpa_stream_t capture_stream_select;
  logic [2:0]  capture_framer_select;
  bpa_chan_t   fr_sel;
  logic [7:0]  sel_byte;
  logic [15:0] stat_word;

  assign cap_en                 = q.ctrl[BPA_EN_BIT];
  assign whole_frame_capture    = q.ctrl[BPA_WHOLE_BIT];
  assign repeat_mode            = q.ctrl[BPA_REPEAT_BIT];
  assign capture_channel_select = q.ctrl[BPA_CHAN_MSB:BPA_CHAN_LSB];
  assign capture_stream_select  = bpa_stream_t'(q.ctrl[BPA_STRM_MSB:BPA_STRM_LSB]);
  assign capture_framer_select  = q.ctrl[BPA_FRM_MSB:BPA_FRM_LSB];
  assign stat_word              = {13'h0000, (q.fsm == BPA_CAP_DONE), q.fsm};

  // ---------------------------------------------------------------
  // Source selection
  // ---------------------------------------------------------------
  always_comb begin
    fr_sel = framer_chan[capture_framer_select];
    unique case (capture_stream_select)
      BPA_STRM_DATA_IN:  sel_byte = fr_sel.data_in;
      BPA_STRM_DATA_OUT: sel_byte = fr_sel.data_out;
      BPA_STRM_SIG_IN:   sel_byte = fr_sel.sig_in;
      BPA_STRM_SIG_OUT:  sel_byte = fr_sel.sig_out;
    endcase
  end

  // ---------------------------------------------------------------
  // Slot timing
  // ---------------------------------------------------------------
  bpa_slot_timer #(
    .CK_PER_CHAN (CK_PER_CHAN)
  ) u_slot (
    .clock       (clock),
    .srst        (srst),
    .frame_pulse (frame_pulse),
    .ck_tick     (sys_ck_tick),
    .rate_fast   (rate_fast),
    .slot        (slot)
  );

  // ---------------------------------------------------------------
  // Registers and capture sequencing
  // ---------------------------------------------------------------
  always_comb begin
    d       = q;
    d.bw.we = 1'b0;
    d.full  = 1'b0;

    if (host_req.cs && host_req.wr) begin
      unique case (host_req.addr)
        BPA_CTRL_ADDR: d.ctrl = host_req.wdata & BPA_CTRL_WMASK;
        BPA_MASK_ADDR: d.mask = host_req.wdata;
        default:       d.ctrl = q.ctrl;
      endcase
    end
    if (host_req.cs && host_req.rd) begin
      unique case (host_req.addr)
        BPA_CTRL_ADDR: d.rdata = q.ctrl;
        BPA_MASK_ADDR: d.rdata = q.mask;
        BPA_STAT_ADDR: d.rdata = stat_word;
        default:       d.rdata = 16'h0000;
      endcase
    end

    unique case (q.fsm)
      BPA_CAP_IDLE: begin
        if (cap_en) begin
          d.fsm = BPA_CAP_ARM;
        end
      end
      BPA_CAP_ARM: begin
        if (!cap_en) begin
          d.fsm = BPA_CAP_IDLE;
        end else if (frame_pulse) begin
          d.fsm  = BPA_CAP_RUN;
          d.fill = '0;
        end
      end
      BPA_CAP_RUN: begin
        if (!cap_en) begin
          d.fsm = BPA_CAP_IDLE;
        end else if (slot.strobe && whole_frame_capture) begin
          if (slot.chan <= BPA_SLOT_W'(BPA_LAST_CAP_CHAN)) begin
            d.bw.we   = 1'b1;
            d.bw.addr = slot.chan[BPA_BUF_AW-1:0];
            d.bw.data = sel_byte;
            if (slot.chan == BPA_SLOT_W'(BPA_LAST_CAP_CHAN)) begin
              d.full = 1'b1;
              if (!repeat_mode) begin
                d.fsm = BPA_CAP_DONE;
              end
            end
          end
        end else if (slot.strobe && slot.chan == {2'b00, capture_channel_select}) begin
          d.bw.we   = 1'b1;
          d.bw.addr = q.fill;
          d.bw.data = sel_byte;
          if (q.fill == BPA_BUF_AW'(FILL_LEN - 1)) begin
            d.fill = '0;
            d.full = 1'b1;
            if (!repeat_mode) begin
              d.fsm = BPA_CAP_DONE;
            end
          end else begin
            d.fill = q.fill + 1'b1;
          end
        end
      end
      BPA_CAP_DONE: begin
        if (!cap_en) begin
          d.fsm = BPA_CAP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q      <= '0;
      q.ctrl <= BPA_CTRL_RST;
      q.mask <= BPA_MASK_RST;
      q.fsm  <= BPA_CAP_IDLE;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Vector status masking
  // ---------------------------------------------------------------
  bpa_vec_mask #(
    .FRAMERS    (BPA_MASK_FRAMERS)
  ) u_mask (
    .clock      (clock),
    .srst       (srst),
    .status_raw (vec_status_raw),
    .mask       (q.mask),
    .status_out (vec_status_out)
  );

  assign host_rdata     = q.rdata;
  assign buf_wr         = q.bw;
  assign cap_full_pulse = q.full;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_single_hit;
    (q.fsm == BPA_CAP_RUN) && cap_en && slot.strobe && !whole_frame_capture
      && (slot.chan == {2'b00, capture_channel_select});
  endsequence

  sequence s_whole_hit;
    (q.fsm == BPA_CAP_RUN) && cap_en && slot.strobe && whole_frame_capture
      && (slot.chan <= BPA_SLOT_W'(BPA_LAST_CAP_CHAN));
  endsequence

  property p_single_write;
    @(posedge clock) disable iff (srst)
      s_single_hit |=> buf_wr.we && (buf_wr.addr == $past(q.fill));
  endproperty
  a_single_write: assert property (p_single_write)
    else $error("selected channel not written");

  property p_stream_data;
    @(posedge clock) disable iff (srst)
      buf_wr.we |-> (buf_wr.data == $past(sel_byte));
  endproperty
  a_stream_data: assert property (p_stream_data)
    else $error("written byte not from selected stream");

  property p_no_write_off;
    @(posedge clock) disable iff (srst)
      !cap_en |=> !buf_wr.we;
  endproperty
  a_no_write_off: assert property (p_no_write_off)
    else $error("buffer written while capture disabled");

  property p_framer0_src;
    @(posedge clock) disable iff (srst)
      (buf_wr.we && ($past(capture_framer_select) == 3'h0)
        && ($past(capture_stream_select) == BPA_STRM_DATA_IN))
        |-> (buf_wr.data == $past(framer_chan[0].data_in));
  endproperty
  a_framer0_src: assert property (p_framer0_src)
    else $error("framer 0 data input byte not captured");

  property p_single_only;
    @(posedge clock) disable iff (srst)
      ((q.fsm == BPA_CAP_RUN) && !whole_frame_capture && slot.strobe
        && (slot.chan != {2'b00, capture_channel_select})) |=> !buf_wr.we;
  endproperty
  a_single_only: assert property (p_single_only)
    else $error("non-selected channel written in per-channel mode");

  property p_whole_write;
    @(posedge clock) disable iff (srst)
      s_whole_hit |=> buf_wr.we && (buf_wr.addr == $past(slot.chan[BPA_BUF_AW-1:0]));
  endproperty
  a_whole_write: assert property (p_whole_write)
    else $error("whole-frame channel not written at its address");

  property p_fill_end;
    @(posedge clock) disable iff (srst)
      cap_full_pulse |-> buf_wr.we
        && (q.fsm == ($past(repeat_mode) ? BPA_CAP_RUN : BPA_CAP_DONE));
  endproperty
  a_fill_end: assert property (p_fill_end)
    else $error("wrong state after buffer full");

  property p_full_pulse;
    @(posedge clock) disable iff (srst)
      cap_full_pulse |=> !cap_full_pulse;
  endproperty
  a_full_pulse: assert property (p_full_pulse)
    else $error("full pulse longer than one cycle");

  property p_mask_reset;
    @(posedge clock)
      srst |=> (q.mask == 16'h0000);
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask register not cleared by reset");

  property p_done_hold;
    @(posedge clock) disable iff (srst)
      (q.fsm == BPA_CAP_DONE) && cap_en |=> (q.fsm == BPA_CAP_DONE) && !buf_wr.we;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("capture resumed without re-enable");

endmodule : bpa_top
`default_nettype wire

// ==== hw/bpa_pkg.sv ====
// Purpose: Shared constants and types of the backplane analyzer and vector mask block.
// Assumes: 16-bit host register interface on global addresses 9xx.
// Notes:   One place for offsets, field positions, reset values and timing counts.
package bpa_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] BPA_CTRL_ADDR = 12'h900;
  localparam logic [11:0] BPA_MASK_ADDR = 12'h901;
  localparam logic [11:0] BPA_STAT_ADDR = 12'h904;
  localparam logic [11:0] BPA_BUF_FIRST = 12'h920;
  localparam logic [11:0] BPA_BUF_LAST  = 12'h93f;

  // ---------------------------------------------------------------
  // Capture control fields and reset values
  // ---------------------------------------------------------------
  localparam int          BPA_CHAN_MSB   = 15;
  localparam int          BPA_CHAN_LSB   = 11;
  localparam int          BPA_STRM_MSB   = 7;
  localparam int          BPA_STRM_LSB   = 6;
  localparam int          BPA_EN_BIT     = 5;
  localparam int          BPA_FRM_MSB    = 4;
  localparam int          BPA_FRM_LSB    = 2;
  localparam int          BPA_WHOLE_BIT  = 1;
  localparam int          BPA_REPEAT_BIT = 0;
  localparam logic [15:0] BPA_CTRL_RST   = 16'h0000;
  localparam logic [15:0] BPA_CTRL_WMASK = 16'hf8ff;
  localparam logic [15:0] BPA_MASK_RST   = 16'h0000;

  // ---------------------------------------------------------------
  // Mask layout: four sources per framer
  // ---------------------------------------------------------------
  localparam int BPA_MASK_FRAMERS = 4;
  localparam int BPA_SRC_PER_FRM  = 4;
  localparam int BPA_SRC_HDLC     = 3;
  localparam int BPA_SRC_ELASTIC  = 2;
  localparam int BPA_SRC_RXLINE   = 1;
  localparam int BPA_SRC_SYNC     = 0;

  // ---------------------------------------------------------------
  // Backplane timing
  // ---------------------------------------------------------------
  localparam int BPA_CK_SLOW_KHZ   = 4096;
  localparam int BPA_CK_FAST_KHZ   = 16384;
  localparam int BPA_CK_PER_BIT    = 2;
  localparam int BPA_BITS_PER_CHAN = 8;
  localparam int BPA_CK_PER_CHAN   = BPA_CK_PER_BIT * BPA_BITS_PER_CHAN;
  localparam int BPA_SLOTS_SLOW    = BPA_CK_SLOW_KHZ / (BPA_CK_PER_CHAN * 8);
  localparam int BPA_SLOTS_FAST    = BPA_CK_FAST_KHZ / (BPA_CK_PER_CHAN * 8);
  localparam int BPA_LAST_CAP_CHAN = 32;
  localparam int BPA_BUF_WORDS     = int'(BPA_BUF_LAST - BPA_BUF_FIRST) + 1;
  localparam int BPA_FRAMERS       = 8;
  localparam int BPA_TICK_W        = 4;
  localparam int BPA_SLOT_W        = 7;
  localparam int BPA_BUF_AW        = 6;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BPA_STRM_DATA_IN  = 2'b00,
    BPA_STRM_DATA_OUT = 2'b01,
    BPA_STRM_SIG_IN   = 2'b10,
    BPA_STRM_SIG_OUT  = 2'b11
  } bpa_stream_t;

  typedef enum logic [1:0] {
    BPA_CAP_IDLE = 2'b00,
    BPA_CAP_ARM  = 2'b01,
    BPA_CAP_RUN  = 2'b10,
    BPA_CAP_DONE = 2'b11
  } bpa_cap_st_t;

  typedef struct packed {
    logic [7:0] data_in;
    logic [7:0] data_out;
    logic [7:0] sig_in;
    logic [7:0] sig_out;
  } bpa_chan_t;

  typedef struct packed {
    logic        cs;
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } bpa_host_req_t;

  typedef struct packed {
    logic                  we;
    logic [BPA_BUF_AW-1:0] addr;
    logic [7:0]            data;
  } bpa_buf_wr_t;

  typedef struct packed {
    logic                  strobe;
    logic [BPA_SLOT_W-1:0] chan;
  } bpa_slot_t;

endpackage : bpa_pkg

// ==== hw/bpa_slot_timer.sv ====
// Purpose: Channel slot timer driven by the system clock tick and the frame pulse.
// Assumes: frame_pulse marks the start of channel 0; ck_tick is one backplane clock.
// Notes:   Emits one strobe at the end of every channel slot of the frame.
`timescale 1ns/1ps
`default_nettype none
module bpa_slot_timer #(
  parameter int CK_PER_CHAN = bpa_pkg::BPA_CK_PER_CHAN
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         srst,
  // Backplane timing
  input  wire logic         frame_pulse,
  input  wire logic         ck_tick,
  input  wire logic         rate_fast,
  // Slot output
  output bpa_pkg::bpa_slot_t slot
);
  import bpa_pkg::*;

  if (CK_PER_CHAN < 1 || CK_PER_CHAN > (1 << BPA_TICK_W)) begin : g_chk
    $error("CK_PER_CHAN out of range");
  end

  typedef struct packed {
    logic                  active;
    logic [BPA_TICK_W-1:0] ticks;
    logic [BPA_SLOT_W-1:0] slot;
    bpa_slot_t             out;
  } bpa_slot_st_t;

  bpa_slot_st_t          q;
  bpa_slot_st_t          d;
  logic [BPA_SLOT_W-1:0] last_slot;

  // ---------------------------------------------------------------
  // Slot counting
  // ---------------------------------------------------------------
  always_comb begin
    last_slot    = rate_fast ? BPA_SLOT_W'(BPA_SLOTS_FAST - 1) : BPA_SLOT_W'(BPA_SLOTS_SLOW - 1);
    d            = q;
    d.out.strobe = 1'b0;
    if (frame_pulse) begin
      d.active = 1'b1;
      d.ticks  = '0;
      d.slot   = '0;
    end else if (q.active && ck_tick) begin
      if (q.ticks == BPA_TICK_W'(CK_PER_CHAN - 1)) begin
        d.ticks      = '0;
        d.out.strobe = 1'b1;
        d.out.chan   = q.slot;
        if (q.slot == last_slot) begin
          d.active = 1'b0;
        end else begin
          d.slot = q.slot + 1'b1;
        end
      end else begin
        d.ticks = q.ticks + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign slot = q.out;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_frame_restart;
    @(posedge clock) disable iff (srst)
      frame_pulse |=> (q.slot == '0) && (q.ticks == '0) && q.active;
  endproperty
  a_frame_restart: assert property (p_frame_restart)
    else $error("frame pulse did not restart slot timing");

endmodule : bpa_slot_timer
`default_nettype wire

// ==== hw/bpa_vec_mask.sv ====
// Purpose: Gates per-framer interrupt vector status bits with their mask bits.
// Assumes: Raw status bits arrive in the same layout as the mask register.
// Notes:   Output is registered, one cycle behind raw status and mask.
`timescale 1ns/1ps
`default_nettype none
module bpa_vec_mask #(
  parameter int FRAMERS = bpa_pkg::BPA_MASK_FRAMERS
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  srst,
  // Status and mask
  input  wire logic [FRAMERS*4-1:0]  status_raw,
  input  wire logic [FRAMERS*4-1:0]  mask,
  output logic      [FRAMERS*4-1:0]  status_out
);
  import bpa_pkg::*;

  if (FRAMERS < 1 || FRAMERS > BPA_FRAMERS) begin : g_chk
    $error("FRAMERS out of range");
  end

  typedef struct packed {
    logic [FRAMERS*BPA_SRC_PER_FRM-1:0] status;
  } bpa_vec_st_t;

  bpa_vec_st_t q;
  bpa_vec_st_t d;
  logic [FRAMERS*BPA_SRC_PER_FRM-1:0] gated;

  // ---------------------------------------------------------------
  // Per-bit gating
  // ---------------------------------------------------------------
  for (genvar i = 0; i < FRAMERS * BPA_SRC_PER_FRM; i++) begin : g_bit
    assign gated[i] = status_raw[i] & ~mask[i];
  end

  always_comb begin
    d        = q;
    d.status = gated;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign status_out = q.status;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_mask_gate;
    @(posedge clock) disable iff (srst)
      1'b1 |=> (status_out == $past(status_raw & ~mask)) && ((status_out & $past(mask)) == '0);
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("masked vector status bit not held at zero");

endmodule : bpa_vec_mask
`default_nettype wire

// ==== test/testbench.sv ====
// Purpose: Self-checking bench for the capture control and vector mask block.
// Assumes: Short fill and slot tick counts; inputs move 1 ns after rising edges.
// Notes:   Expected reads and buffer writes are queued; a monitor pops them.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bpa_pkg::*;
  localparam int FILL = 4;
  localparam int CKC  = 2;
  logic            clock = 1'b0;
  logic            srst = 1'b1;
  bpa_host_req_t   host_req = '0;
  logic [15:0]     host_rdata;
  logic            frame_pulse = 1'b0;
  logic            sys_ck_tick = 1'b0;
  logic            rate_fast = 1'b0;
  bpa_chan_t [7:0] framer_chan = '0;
  bpa_buf_wr_t     buf_wr;
  logic            cap_full_pulse;
  logic [15:0]     vec_status_raw = '0;
  logic [15:0]     vec_status_out;
  int              errors = 0;
  int              check_count = 0;
  int              seed = 32'hb2e3;
  logic [15:0]     rd_q[$];
  logic [14:0]     wr_q[$];
  logic            rd_taken = 1'b0;
  logic [15:0]     mask_m = '0;
  logic [15:0]     vec_exp = '0;
  logic [15:0]     ctrl_m = '0;
  logic [15:0]     c;
  int              fill_m = 0;
  bit              cap_on = 1'b0;

  always #12.5 clock = ~clock;

  bpa_top #(.FILL_LEN(FILL), .CK_PER_CHAN(CKC)) DUT (
    .clock(clock), .srst(srst), .host_req(host_req), .host_rdata(host_rdata),
    .frame_pulse(frame_pulse), .sys_ck_tick(sys_ck_tick), .rate_fast(rate_fast),
    .framer_chan(framer_chan), .buf_wr(buf_wr), .cap_full_pulse(cap_full_pulse),
    .vec_status_raw(vec_status_raw), .vec_status_out(vec_status_out));

  // ---------------------------------------------------------------
  // Compare and closing tasks
  // ---------------------------------------------------------------
  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp16

  task automatic cmp_wr(input logic [14:0] exp, input logic [14:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] buffer write expected %h seen %h", exp, got);
    end
  endtask : cmp_wr

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------
  // Monitor: mask model and queued results
  // ---------------------------------------------------------------
  always @(posedge clock) vec_status_raw <= #1 16'($random(seed));

  always @(posedge clock) begin
    rd_taken <= host_req.cs && host_req.rd && !srst;
    vec_exp <= srst ? 16'h0000 : (vec_status_raw & ~mask_m);
    if (srst)
      mask_m <= '0;
    else if (host_req.cs && host_req.wr && host_req.addr == BPA_MASK_ADDR)
      mask_m <= host_req.wdata;
  end

  always @(negedge clock) begin
    if (!srst) begin
      cmp16("vector status", vec_exp, vec_status_out);
      cmp16("lone full", 16'h0000, {15'h0000, cap_full_pulse & ~buf_wr.we});
      if (rd_taken)
        cmp16("read data", rd_q.pop_front(), host_rdata);
      if (buf_wr.we === 1'b1)
        cmp_wr(wr_q.size() > 0 ? wr_q.pop_front() : 15'bx,
               {cap_full_pulse, buf_wr.addr, buf_wr.data});
    end
  end

  // ---------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------
  task automatic host_wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clock);
    #1 host_req = '{cs: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    #1 host_req = '0;
    if (a == BPA_CTRL_ADDR) begin
      ctrl_m = d & BPA_CTRL_WMASK;
      cap_on = d[BPA_EN_BIT];
      fill_m = 0;
    end
  endtask : host_wr

  task automatic host_rd(input logic [11:0] a, input logic [15:0] exp);
    rd_q.push_back(exp);
    @(posedge clock);
    #1 host_req = '{cs: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clock);
    #1 host_req = '0;
  endtask : host_rd

  function automatic logic [7:0] pick(input bpa_chan_t ch, input logic [1:0] s);
    case (s)
      BPA_STRM_DATA_IN:  return ch.data_in;
      BPA_STRM_DATA_OUT: return ch.data_out;
      BPA_STRM_SIG_IN:   return ch.sig_in;
      default:           return ch.sig_out;
    endcase
  endfunction : pick

  // One frame; slot bytes stay put from first tick until after the strobe
  task automatic run_frame();
    logic [7:0] b;
    repeat (3) @(posedge clock);
    #1 frame_pulse = 1'b1;
    @(posedge clock);
    #1 frame_pulse = 1'b0;
    for (int s = 0; s < (rate_fast ? 128 : 32); s++) begin
      for (int f = 0; f < 8; f++) framer_chan[f] = bpa_chan_t'($random(seed));
      b = pick(framer_chan[ctrl_m[4:2]], ctrl_m[7:6]);
      if (cap_on && ctrl_m[1] && s <= 32) begin
        wr_q.push_back({s == 32, 6'(s), b});
        if (s == 32 && !ctrl_m[0]) cap_on = 1'b0;
      end else if (cap_on && !ctrl_m[1] && s == ctrl_m[15:11]) begin
        wr_q.push_back({fill_m == FILL - 1, 6'(fill_m), b});
        fill_m = (fill_m + 1) % FILL;
        if (fill_m == 0 && !ctrl_m[0]) cap_on = 1'b0;
      end
      for (int t = 0; t < CKC; t++) begin
        sys_ck_tick = 1'b1;
        @(posedge clock);
        #1 sys_ck_tick = 1'b0;
        @(posedge clock);
        #1;
      end
    end
  endtask : run_frame

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin : watchdog
    repeat (40000) @(posedge clock);
    errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    tally_and_finish();
  end

  initial begin : main
    repeat (20) @(posedge clock);
    #1 srst = 1'b0;
    host_rd(BPA_CTRL_ADDR, BPA_CTRL_RST);
    host_rd(BPA_MASK_ADDR, BPA_MASK_RST);
    host_rd(BPA_BUF_FIRST, 16'h0000);
    host_wr(BPA_CTRL_ADDR, 16'hffdf);
    host_rd(BPA_CTRL_ADDR, 16'hf8df);
    host_wr(BPA_STAT_ADDR, 16'hffff);
    host_rd(BPA_STAT_ADDR, 16'h0000);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      c = (i < 4) ? (16'h000f << (4 * i)) : 16'($random(seed));
      host_wr(BPA_MASK_ADDR, c);
      host_rd(BPA_MASK_ADDR, c);
      repeat (8) @(posedge clock);
    end
    $display("test mask done");
    for (int s = 0; s < 4; s++) begin
      rate_fast = s[0];
      c = {5'($random(seed)), 3'b000, 2'(s), 1'b1, 3'(3 * s), 1'b0, s[1]};
      host_wr(BPA_CTRL_ADDR, c);
      host_rd(BPA_STAT_ADDR, 16'h0001);
      repeat (FILL + 1) run_frame();
      host_rd(BPA_STAT_ADDR, s[1] ? 16'h0002 : 16'h0007);
      host_wr(BPA_CTRL_ADDR, 16'h0000);
      host_rd(BPA_STAT_ADDR, 16'h0000);
    end
    cmp16("pending writes", 16'h0000, 16'(wr_q.size()));
    $display("test single channel done");
    rate_fast = 1'b1;
    c = {8'h00, 2'b11, 1'b1, 3'($random(seed)), 2'b11};
    host_wr(BPA_CTRL_ADDR, c);
    repeat (2) run_frame();
    host_rd(BPA_STAT_ADDR, 16'h0002);
    host_wr(BPA_CTRL_ADDR, c & 16'hffdf);
    run_frame();
    rate_fast = 1'b0;
    c = {8'h00, 2'b01, 1'b1, 3'($random(seed)), 2'b10};
    host_wr(BPA_CTRL_ADDR, c);
    run_frame();
    host_rd(BPA_STAT_ADDR, 16'h0002);
    host_wr(BPA_CTRL_ADDR, 16'h0000);
    repeat (4) @(posedge clock);
    cmp16("pending writes", 16'h0000, 16'(wr_q.size()));
    $display("test whole frame done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
